// *** logic/plc_defines.svh ***
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PLC_ADDR_PLL_CONTROL_REG 8'h00
`define PLC_ADDR_CFG 8'h01
`define PLC_ADDR_STAT 8'h02
`define PLC_ADDR_IRQ_STAT 8'h03
`define PLC_ADDR_IRQ_MASK 8'h04

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PLC_PLL_CONTROL_REG_IRQ_EN 7
`define PLC_PLL_CONTROL_REG_FLAG 6
`define PLC_PLL_CONTROL_REG_PLL_ON 5
`define PLC_PLL_CONTROL_REG_BCS 4
`define PLC_CFG_OSC_STOP 0
`define PLC_CFG_AUTO 1
`define PLC_STAT_LOCK 0
`define PLC_STAT_MODE_LO 1
`define PLC_STAT_BREAK 4
`define PLC_IRQ_PLL 0
`define PLC_IRQ_STOP_EXIT 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PLC_RST_BIT 1'h0
`define PLC_RST_MASK 2'h0
`define PLC_RST_DATA 8'h00

`endif

// *** logic/plc_pkg.sv ***
package plc_pkg;

	typedef enum logic [2:0] {
		MODE_RUN = 3'h1,
		MODE_WAIT = 3'h2,
		MODE_STOP = 3'h4
	} plc_mode_type;

	typedef struct packed {
		logic prev;
		logic half;
	} plc_div_state_type;

endpackage

// *** logic/plc_div_if.sv ***
`timescale 1ns/1ps
interface plc_div_if;
	logic src;
	logic run;
	logic half;
	modport div (input src, input run, output half);
	modport user (output src, output run, input half);
endinterface

// *** logic/plc_div2.sv ***
`timescale 1ns/1ps
`include "plc_defines.svh"
// halves a clock that arrives as a sampled level; held low while not running
module plc_div2 (
	input wire logic clk_i,
	input wire logic rst_n,
	plc_div_if.div port
);
	plc_pkg::plc_div_state_type st;
	plc_pkg::plc_div_state_type next_st;

	always_comb begin
		next_st = st;
		next_st.prev = port.src;
		if (!port.run) begin
			next_st.half = `PLC_RST_BIT;
		end else if (port.src && !st.prev) begin
			next_st.half = ~st.half;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign port.half = st.half;
endmodule // plc_div2

// *** logic/plc_top.sv ***
// How it works
// - wait leaves oscillator, PLL, selection unchanged
// - deselected but enabled PLL keeps running in wait
// - stop without osc enable gates clocks, enables and clockgen irq low
// - stop entry clears VCO source select
// - after stop, crystal half drives main output
// - osc-in-stop enabled: only PLL turns off
// - flag cleared in break stays cleared
// - break without clear enable protects PLL flag
// - auto mode flags every lock change; else zero
// - select bit picks VCO half or crystal half
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "plc_defines.svh"
module plc_top (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic wait_i,
	input wire logic stop_i,
	input wire logic break_i,
	input wire logic break_clear_enable_i,
	input wire logic pll_lock_i,
	input wire logic crystal_clk_i,
	input wire logic vco_clock_i,
	output logic osc_enable_o,
	output logic pll_enable_o,
	output logic crystal_clock_out_o,
	output logic main_clock_out_o,
	output logic clockgen_irq_out_o,
	output logic irq_o
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'h1};
		end
	end
	assign rst_n = rst_sync[1];

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		plc_pkg::plc_mode_type mode;
		logic irq_en;
		logic flag;
		logic pll_on;
		logic base_clock_source_select;
		logic osc_in_stop;
		logic cfg_done;
		logic auto_bw;
		logic lock_prev;
		logic stop_exit;
		logic [1:0] mask;
		logic xtal_out;
		logic main_out;
		logic cg_irq;
		logic [7:0] rdata;
	} plc_state_type;

	plc_state_type st;
	plc_state_type next_st;

	plc_div_if xtal_div ();
	plc_div_if vco_div ();

	logic gated_off;
	logic stop_entry;
	logic lock_event;
	logic clear_ok;
	logic wr_pll_control_reg;
	logic wr_irq;
	logic [7:0] pll_control_reg_rd;
	logic [7:0] cfg_rd;
	logic [7:0] stat_rd;
	logic [1:0] irq_stat;

	// oscillator dark only in stop without osc enable
	assign gated_off = (st.mode == plc_pkg::MODE_STOP) && !st.osc_in_stop;
	// stop and wait are plain synchronous levels from the core logic
	assign stop_entry = stop_i && (st.mode != plc_pkg::MODE_STOP);
	assign lock_event = st.auto_bw && (pll_lock_i != st.lock_prev);
	// break with clear enable low makes every flag clear a no-op
	assign clear_ok = !break_i || break_clear_enable_i;
	assign wr_pll_control_reg = wr_i && (addr_i == `PLC_ADDR_PLL_CONTROL_REG);
	assign wr_irq = wr_i && (addr_i == `PLC_ADDR_IRQ_STAT);
	assign irq_stat = {st.stop_exit, st.flag};

	// wait does not touch any of these terms
	assign osc_enable_o = !gated_off;
	assign pll_enable_o = st.pll_on && (st.mode != plc_pkg::MODE_STOP);

	assign xtal_div.src = crystal_clk_i;
	assign xtal_div.run = !gated_off;
	assign vco_div.src = vco_clock_i;
	assign vco_div.run = pll_enable_o;

	plc_div2 u_xtal_div (
		.clk_i(clk_i),
		.rst_n(rst_n),
		.port(xtal_div.div)
	);

	plc_div2 u_vco_div (
		.clk_i(clk_i),
		.rst_n(rst_n),
		.port(vco_div.div)
	);

	always_comb begin
		pll_control_reg_rd = 8'h00;
		pll_control_reg_rd[`PLC_PLL_CONTROL_REG_IRQ_EN] = st.irq_en;
		pll_control_reg_rd[`PLC_PLL_CONTROL_REG_FLAG] = st.flag;
		pll_control_reg_rd[`PLC_PLL_CONTROL_REG_PLL_ON] = st.pll_on;
		pll_control_reg_rd[`PLC_PLL_CONTROL_REG_BCS] = st.base_clock_source_select;
		cfg_rd = 8'h00;
		cfg_rd[`PLC_CFG_OSC_STOP] = st.osc_in_stop;
		cfg_rd[`PLC_CFG_AUTO] = st.auto_bw;
		stat_rd = 8'h00;
		stat_rd[`PLC_STAT_LOCK] = st.auto_bw && pll_lock_i;
		stat_rd[`PLC_STAT_MODE_LO +: 3] = st.mode;
		stat_rd[`PLC_STAT_BREAK] = break_i;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.lock_prev = pll_lock_i;
		case (st.mode)
			plc_pkg::MODE_RUN: begin
				if (stop_i) begin
					next_st.mode = plc_pkg::MODE_STOP;
				end else if (wait_i) begin
					next_st.mode = plc_pkg::MODE_WAIT;
				end
			end
			plc_pkg::MODE_WAIT: begin
				if (stop_i) begin
					next_st.mode = plc_pkg::MODE_STOP;
				end else if (!wait_i) begin
					next_st.mode = plc_pkg::MODE_RUN;
				end
			end
			plc_pkg::MODE_STOP: begin
				if (!stop_i) begin
					next_st.mode = wait_i ? plc_pkg::MODE_WAIT : plc_pkg::MODE_RUN;
				end
			end
			default: begin
				next_st.mode = plc_pkg::MODE_RUN;
			end
		endcase
		if (wr_pll_control_reg) begin
			next_st.irq_en = wdata_i[`PLC_PLL_CONTROL_REG_IRQ_EN];
			next_st.pll_on = wdata_i[`PLC_PLL_CONTROL_REG_PLL_ON];
			next_st.base_clock_source_select = wdata_i[`PLC_PLL_CONTROL_REG_BCS];
		end
		// stop entry and stop force the crystal half; bcs stays low until written outside stop
		if (stop_entry || st.mode == plc_pkg::MODE_STOP) begin
			next_st.base_clock_source_select = `PLC_RST_BIT;
		end
		if (wr_i && addr_i == `PLC_ADDR_CFG) begin
			next_st.auto_bw = wdata_i[`PLC_CFG_AUTO];
			if (!st.cfg_done) begin
				next_st.osc_in_stop = wdata_i[`PLC_CFG_OSC_STOP];
				next_st.cfg_done = 1'h1;
			end
		end
		if (wr_i && addr_i == `PLC_ADDR_IRQ_MASK) begin
			next_st.mask = wdata_i[1:0];
		end
		// clears first, so a same-cycle event wins; a done clear is kept
		if (clear_ok && ((wr_pll_control_reg && wdata_i[`PLC_PLL_CONTROL_REG_FLAG]) ||
			(wr_irq && wdata_i[`PLC_IRQ_PLL]))) begin
			next_st.flag = `PLC_RST_BIT;
		end
		if (clear_ok && wr_irq && wdata_i[`PLC_IRQ_STOP_EXIT]) begin
			next_st.stop_exit = `PLC_RST_BIT;
		end
		if (lock_event) begin
			next_st.flag = 1'h1;
		end
		if (!st.auto_bw) begin
			next_st.flag = `PLC_RST_BIT;
		end
		if (st.mode == plc_pkg::MODE_STOP && !stop_i) begin
			next_st.stop_exit = 1'h1;
		end
		next_st.xtal_out = crystal_clk_i && !gated_off;
		next_st.main_out = gated_off ? 1'h0 : (st.base_clock_source_select ? vco_div.half : xtal_div.half);
		next_st.cg_irq = st.flag && st.irq_en && !gated_off;
		next_st.rdata = `PLC_RST_DATA;
		if (rd_i) begin
			case (addr_i)
				`PLC_ADDR_PLL_CONTROL_REG: next_st.rdata = pll_control_reg_rd;
				`PLC_ADDR_CFG: next_st.rdata = cfg_rd;
				`PLC_ADDR_STAT: next_st.rdata = stat_rd;
				`PLC_ADDR_IRQ_STAT: next_st.rdata = {6'h00, irq_stat};
				`PLC_ADDR_IRQ_MASK: next_st.rdata = {6'h00, st.mask};
				default: next_st.rdata = `PLC_RST_DATA;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.mode <= plc_pkg::MODE_RUN;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign crystal_clock_out_o = st.xtal_out;
	assign main_clock_out_o = st.main_out;
	assign clockgen_irq_out_o = st.cg_irq;
	assign irq_o = |(irq_stat & st.mask);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	wait_keeps_clock_a: assert property (
		(st.mode == plc_pkg::MODE_WAIT && !stop_i && !wr_pll_control_reg) |=>
			$stable(st.base_clock_source_select) && osc_enable_o && pll_enable_o == $past(st.pll_on))
		else $error("wait changed the clock generator");

	wait_pll_runs_a: assert property (
		(wait_i && st.pll_on && !st.base_clock_source_select && st.mode != plc_pkg::MODE_STOP) |-> pll_enable_o)
		else $error("deselected pll stopped in wait");

	stop_gates_low_a: assert property (
		(gated_off ##1 gated_off) |-> !crystal_clock_out_o && !main_clock_out_o &&
			!clockgen_irq_out_o && !osc_enable_o && !pll_enable_o)
		else $error("stop left clock outputs active");

	stop_clears_sel_a: assert property (
		(stop_entry && st.base_clock_source_select) |=> !st.base_clock_source_select ##1
			(main_clock_out_o == $past(xtal_div.half) || $past(gated_off)))
		else $error("stop did not drop vco source");

	after_stop_xtal_a: assert property (
		(st.mode == plc_pkg::MODE_STOP && !stop_i) ##1 !wr_pll_control_reg |-> !st.base_clock_source_select)
		else $error("vco source set after stop exit");

	osc_runs_stop_a: assert property (
		(st.mode == plc_pkg::MODE_STOP && st.osc_in_stop) |-> osc_enable_o && !pll_enable_o)
		else $error("osc run in stop not honoured");

	break_clear_kept_a: assert property (
		(break_i && !st.flag && !lock_event) |=> !st.flag)
		else $error("flag restored during break");

	break_protect_a: assert property (
		(break_i && !break_clear_enable_i && st.flag && st.auto_bw && wr_i) |=> st.flag)
		else $error("protected flag cleared in break");

	lock_sets_flag_a: assert property (
		lock_event |=> st.flag)
		else $error("lock change did not set flag");

	manual_flag_zero_a: assert property (
		!st.auto_bw |=> !st.flag)
		else $error("flag set in manual bandwidth mode");

	source_select_a: assert property (
		(!gated_off && st.base_clock_source_select) |=> main_clock_out_o == $past(vco_div.half))
		else $error("main output not from vco half");

	stop_entry_a: assert property (
		stop_entry |=> st.mode == plc_pkg::MODE_STOP && !pll_enable_o)
		else $error("stop entry not taken at the next edge");

	wait_holds_a: assert property (
		(st.mode == plc_pkg::MODE_WAIT && wait_i && !stop_i) |=> st.mode == plc_pkg::MODE_WAIT)
		else $error("wait left while still requested");

	stop_exit_flag_a: assert property (
		(st.mode == plc_pkg::MODE_STOP && !stop_i) |=>
			st.stop_exit && st.mode != plc_pkg::MODE_STOP)
		else $error("stop exit not recorded");

	stop_with_vco_c: cover property (stop_entry && st.base_clock_source_select);
	break_protect_c: cover property (break_i && !break_clear_enable_i && st.flag && wr_irq);
	lock_irq_c: cover property (lock_event && st.irq_en ##1 clockgen_irq_out_o);
	osc_in_stop_c: cover property (st.mode == plc_pkg::MODE_STOP && st.osc_in_stop);
	wait_deselect_c: cover property (st.mode == plc_pkg::MODE_WAIT && st.pll_on && !st.base_clock_source_select);
endmodule // plc_top

// *** dv/plc_core_model.sv ***
`timescale 1ns/1ps
// far side: oscillator and pll analog parts as seen by the control block
module plc_core_model (
	input wire logic clk_i,
	input wire logic lock_req_i,
	input wire logic osc_enable_i,
	input wire logic pll_enable_i,
	output logic crystal_clk_o,
	output logic vco_clock_o,
	output logic pll_lock_o
);
	logic [1:0] div;

	initial begin
		div = 2'h0;
		vco_clock_o = 1'b0;
		pll_lock_o = 1'b0;
	end

	// ---------------------------------------------------------------
	// clock sources
	// ---------------------------------------------------------------
	// a powered-down source stands still low, it never shows a stale level
	always @(posedge clk_i) begin
		// an unknown enable before reset counts as off, or the counter stays unknown
		div <= (osc_enable_i === 1'b1) ? div + 2'h1 : 2'h0;
		vco_clock_o <= (pll_enable_i === 1'b1) ? ~vco_clock_o : 1'b0;
		// lock drops as soon as the pll loses power, giving a lock event
		pll_lock_o <= (pll_enable_i === 1'b1) & lock_req_i;
	end

	assign crystal_clk_o = div[1];
endmodule // plc_core_model

// *** dv/plc_tb.sv ***
`timescale 1ns/1ps
module tb;
	logic clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, rd_v;
	logic wait_i = 1'b0, stop_i = 1'b0, break_i = 1'b0, bce = 1'b0, lock_req = 1'b0;
	logic pll_lock_i, crystal_clk_i, vco_clock_i, osc_enable_o, pll_enable_o;
	logic crystal_clock_out_o, main_clock_out_o, clockgen_irq_out_o, irq_o, saw;
	int errors = 0, num_checks = 0, cycles = 0;

	plc_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wait_i(wait_i), .stop_i(stop_i),
		.break_i(break_i), .break_clear_enable_i(bce), .pll_lock_i(pll_lock_i),
		.crystal_clk_i(crystal_clk_i), .vco_clock_i(vco_clock_i),
		.osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o),
		.crystal_clock_out_o(crystal_clock_out_o), .main_clock_out_o(main_clock_out_o),
		.clockgen_irq_out_o(clockgen_irq_out_o), .irq_o(irq_o));

	plc_core_model far (.clk_i(clk_i), .lock_req_i(lock_req), .osc_enable_i(osc_enable_o),
		.pll_enable_i(pll_enable_o), .crystal_clk_o(crystal_clk_i),
		.vco_clock_o(vco_clock_i), .pll_lock_o(pll_lock_i));

	initial begin
		forever #25 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// bus and compare tasks
	// ---------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rd_v = rdata_o;
	endtask

	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// the whole sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		do_reset();
		rd(8'h02);
		chk(8'h02, rd_v);
		rd(8'h07);
		chk(8'h00, rd_v);
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h30);
		chk(8'h01, {7'h0, pll_enable_o});
		wait_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk(8'h03, {6'h0, osc_enable_o, pll_enable_o});
		rd(8'h02);
		chk(8'h04, rd_v);
		rd(8'h00);
		chk(8'h30, rd_v & 8'h30);
		$display("test wait done");
		wr(8'h00, 8'h20);
		lock_req <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(8'h02);
		chk(8'h05, rd_v);
		rd(8'h03);
		chk(8'h01, rd_v);
		wr(8'h04, 8'h01);
		chk(8'h01, {7'h0, irq_o});
		wr(8'h03, 8'h01);
		chk(8'h00, {7'h0, irq_o});
		chk(8'h01, {7'h0, pll_enable_o});
		wait_i <= 1'b0;
		$display("test lock done");
		lock_req <= 1'b0;
		repeat (4) @(posedge clk_i);
		break_i <= 1'b1;
		wr(8'h00, 8'h70);
		rd(8'h00);
		chk(8'h70, rd_v);
		bce <= 1'b1;
		wr(8'h00, 8'h70);
		rd(8'h00);
		chk(8'h30, rd_v);
		break_i <= 1'b0;
		bce <= 1'b0;
		rd(8'h00);
		chk(8'h30, rd_v);
		wr(8'h00, 8'h00);
		chk(8'h00, {7'h0, pll_enable_o});
		$display("test break done");
		for (int i = 0; i < 2; i++) begin
			do_reset();
			wr(8'h01, {7'h01, i[0]});
			wr(8'h00, 8'h30);
			stop_i <= 1'b1;
			repeat (3) @(posedge clk_i);
			#1;
			chk({6'h0, i[0], 1'b0}, {6'h0, osc_enable_o, pll_enable_o});
			chk(8'h00, {7'h0, clockgen_irq_out_o});
			if (i == 0)
				chk(8'h00, {6'h0, crystal_clock_out_o, main_clock_out_o});
			saw = 1'b0;
			repeat (8) begin
				@(posedge clk_i);
				#1;
				saw = saw | crystal_clock_out_o;
			end
			chk({7'h0, i[0]}, {7'h0, saw});
			rd(8'h00);
			chk(8'h00, rd_v & 8'h10);
			stop_i <= 1'b0;
			rd(8'h03);
			chk(8'h02, rd_v & 8'h02);
			saw = 1'b0;
			repeat (12) begin
				@(posedge clk_i);
				#1;
				saw = saw | main_clock_out_o;
			end
			chk(8'h01, {7'h0, saw});
			rd(8'h00);
			chk(8'h20, rd_v & 8'h30);
			$display("test stop %0d done", i);
		end
		stop_test();
	end
endmodule // tb
